// File: shared/lcdw_pkg.sv
// Constants, types and decode helpers for the LCD display RAM write path
package lcdw_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int COLS = 60;
  localparam int ROWS = 4;
  localparam int BYTE_W = 8;
  localparam logic [7:0] COL_COUNT = 8'h3C;

  // ----------------------------------------------------------------
  // Command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_LDPTR_BIT = 7;
  localparam logic [4:0] CMD_DEVSEL_PFX = 5'h1C;
  localparam logic [5:0] CMD_BANK_PFX = 6'h3E;
  localparam logic [3:0] CMD_MODE_PFX = 4'hC;
  localparam int BANK_IN_BIT = 1;
  localparam int BANK_OUT_BIT = 0;

  // ----------------------------------------------------------------
  // Pointer steps per drive mode
  // ----------------------------------------------------------------
  localparam logic [7:0] STEP_STATIC = 8'h08;
  localparam logic [7:0] STEP_DUPLEX = 8'h04;
  localparam logic [7:0] STEP_TRIPLE = 8'h03;
  localparam logic [7:0] STEP_QUAD = 8'h02;

  // ----------------------------------------------------------------
  // Row numbers
  // ----------------------------------------------------------------
  localparam logic [1:0] ROW_FIRST = 2'h0;
  localparam logic [1:0] ROW_LAST_STATIC = 2'h0;
  localparam logic [1:0] ROW_LAST_DUPLEX = 2'h1;
  localparam logic [1:0] ROW_LAST_TRIPLE = 2'h2;
  localparam logic [1:0] ROW_LAST_QUAD = 2'h3;
  localparam logic [1:0] BANK_ROW_OFS = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_QUAD = 2'h0,
    MODE_STATIC = 2'h1,
    MODE_DUPLEX = 2'h2,
    MODE_TRIPLE = 2'h3
  } lcdw_mode_t;

  typedef struct packed {
    logic [2:0] coff;
    logic [1:0] row;
  } lcdw_bitmap_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam lcdw_mode_t RST_MODE = MODE_QUAD;
  localparam logic [6:0] RST_PTR = 7'h00;
  localparam logic [2:0] RST_SUB = 3'h0;
  localparam logic RST_BANK = 1'h0;
  localparam logic RST_SYNC_IDLE = 1'h1;
  localparam logic [1:0] RST_ROW = 2'h0;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lcdw_step(lcdw_mode_t mode);
    unique case (mode)
      MODE_STATIC: return STEP_STATIC;
      MODE_DUPLEX: return STEP_DUPLEX;
      MODE_TRIPLE: return STEP_TRIPLE;
      MODE_QUAD: return STEP_QUAD;
    endcase
  endfunction : lcdw_step

  function automatic logic [1:0] lcdw_last_row(lcdw_mode_t mode);
    unique case (mode)
      MODE_STATIC: return ROW_LAST_STATIC;
      MODE_DUPLEX: return ROW_LAST_DUPLEX;
      MODE_TRIPLE: return ROW_LAST_TRIPLE;
      MODE_QUAD: return ROW_LAST_QUAD;
    endcase
  endfunction : lcdw_last_row

  function automatic logic lcdw_has_banks(lcdw_mode_t mode);
    return (mode == MODE_STATIC) || (mode == MODE_DUPLEX);
  endfunction : lcdw_has_banks

  // Bit k counts from the byte's MSB
  function automatic lcdw_bitmap_t lcdw_map_bit(lcdw_mode_t mode,
                                               logic [2:0] k, logic bank);
    lcdw_bitmap_t m;
    m = '0;
    unique case (mode)
      MODE_STATIC: begin
        m.coff = k;
        m.row = ROW_FIRST;
      end
      MODE_DUPLEX: begin
        m.coff = k >> 1;
        m.row = {1'b0, k[0]};
      end
      MODE_TRIPLE: begin
        m.coff = k / 3'h3;
        m.row = 2'(k % 3'h3);
      end
      MODE_QUAD: begin
        m.coff = k >> 2;
        m.row = k[1:0];
      end
    endcase
    if (bank && lcdw_has_banks(mode)) begin
      m.row = m.row | BANK_ROW_OFS;
    end
    return m;
  endfunction : lcdw_map_bit

endpackage : lcdw_pkg

// File: shared/lcdw_scan_if.sv
// Scan link between the RAM core and the row sequencer
`timescale 1ns/100ps
interface lcdw_scan_if import lcdw_pkg::*; ();
  lcdw_mode_t mode;
  logic step;
  logic resync;
  logic [1:0] row;
  logic load;

  modport seq (input mode, input step, input resync, output row, output load);
  modport core (output mode, output step, output resync, input row,
    input load);
endinterface : lcdw_scan_if

// File: rtl/lcdw_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module lcdw_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lcdw_sync_st_t;

  lcdw_sync_st_t st_q;
  lcdw_sync_st_t st_d;

  always_comb begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule : lcdw_sync2

// File: rtl/lcdw_row_seq.sv
// Row scan sequencer for the display register
`timescale 1ns/100ps
module lcdw_row_seq import lcdw_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Scan link to the RAM core
  lcdw_scan_if.seq scan
);

  typedef struct packed {
    logic [1:0] row;
    logic load;
  } lcdw_seq_st_t;

  lcdw_seq_st_t st_q;
  lcdw_seq_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.load = scan.step || scan.resync;
    if (scan.resync) begin
      // [R16] restart at last row
      st_d.row = lcdw_last_row(scan.mode);
    end else if (scan.step) begin
      // [R15] cycle active rows
      if (st_q.row >= lcdw_last_row(scan.mode)) begin
        st_d.row = ROW_FIRST;
      end else begin
        st_d.row = st_q.row + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{row: RST_ROW, load: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign scan.row = st_q.row;
  assign scan.load = st_q.load;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_resync_row_start: // [R16]
    assert property (scan.resync |=>
      scan.row == lcdw_last_row($past(scan.mode)) && scan.load)
    else $error("row not restarted at mode's last row");

  a_row_wraps_first: // [R15]
    assert property (scan.step && !scan.resync &&
      scan.row == lcdw_last_row(scan.mode) |=> scan.row == ROW_FIRST)
    else $error("row did not wrap to row 0");

  a_row_stays_range: // [R15]
    assert property (scan.step && !scan.resync |=>
      scan.row <= lcdw_last_row($past(scan.mode)))
    else $error("row beyond mode's last row");

  c_resync_seen:
    cover property (scan.resync ##1 scan.load);

endmodule : lcdw_row_seq

// File: rtl/lcdw_top.sv
// Display RAM write path of a cascadable segment LCD driver
// ------------------------------------------------------------------
// Operation
// [R1] Static: byte fills row 0, eight columns
// [R2] Two-plane: bit pairs into rows 0 and 1
// [R3] Three-plane: MSB-first triples, last row-2 bit kept
// [R4] Four-plane: quadruples into rows 0-3, two columns
// [R5] Pointer steps 8, 4, 3, 2 per mode
// [R6] Load pointer; next byte starts there
// [R7] Host reloads pointer after aborted transfer
// [R8] Store only when counter equals subaddress pins
// [R9] Mismatch discards byte but still advances pointer
// [R10] Pointer overflow increments subaddress counter
// [R11] Device-select loads subaddress counter
// [R12] Host selects device, then loads pointer
// [R13] Host keeps subaddress pins stable during access
// [R14] Three-plane byte overwrites rows 0 and 1
// [R15] Output row cycles per drive mode
// [R16] Resync restarts at mode's last row
// [R17] Output bank shows rows 2/3 instead
// [R18] Input bank writes rows 2/3 instead
// [R19] Input and output banks kept separately
// [R20] Bank command 111110, bit1 input, bit0 output
// [R21] Pointer command: MSB zero, seven-bit column
// [R22] Device-select 11100 plus three-bit counter value
// [R23] Mode codes: 01 static, 10, 11, 00
// [R24] Overflow wraps pointer to zero with counter
// ------------------------------------------------------------------
`timescale 1ns/100ps
module lcdw_top import lcdw_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded bus bytes
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  // Pins from outside the clock domain
  input wire logic hw_subaddr_bit0_pin,
  input wire logic hw_subaddr_bit1_pin,
  input wire logic hw_subaddr_bit2_pin,
  input wire logic lcd_clk_pin,
  input wire logic sync_pin_n,
  // Display register and backplane phase
  output logic [COLS-1:0] segment_data,
  output logic segment_out_first,
  output logic segment_out_last,
  output logic backplane_out_0,
  output logic backplane_out_1,
  output logic backplane_out_2,
  output logic backplane_out_3,
  output logic [1:0] row_index,
  // Status
  output logic [6:0] data_ptr,
  output logic [2:0] subaddr_cnt,
  output logic [1:0] drive_mode,
  output logic bank_in_sel,
  output logic bank_out_sel,
  output logic store_match
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COLS-1:0][ROWS-1:0] ram;
    logic [6:0] ptr;
    logic [2:0] sub;
    lcdw_mode_t mode;
    logic bank_in;
    logic bank_out;
    logic lclk_d;
    logic sync_d;
    logic [COLS-1:0] disp;
    logic [ROWS-1:0] bp;
  } lcdw_core_st_t;

  localparam lcdw_core_st_t CORE_RST = '{
    ram: '0,
    ptr: RST_PTR,
    sub: RST_SUB,
    mode: RST_MODE,
    bank_in: RST_BANK,
    bank_out: RST_BANK,
    lclk_d: 1'b0,
    sync_d: RST_SYNC_IDLE,
    disp: '0,
    bp: '0
  };

  lcdw_core_st_t st_q;
  lcdw_core_st_t st_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s;

  // Sync enters inverted so the stage's reset level is the idle level
  lcdw_sync2 #(
    .W(5)
  ) u_pins (
    .clk(clk),
    .rst(rst),
    .async_in({~sync_pin_n, lcd_clk_pin, hw_subaddr_bit2_pin,
      hw_subaddr_bit1_pin, hw_subaddr_bit0_pin}),
    .sync_out(pin_s)
  );

  // ----------------------------------------------------------------
  // Row sequencer
  // ----------------------------------------------------------------
  lcdw_scan_if scan ();

  lcdw_row_seq u_seq (
    .clk(clk),
    .rst(rst),
    .scan(scan)
  );

  assign scan.mode = st_q.mode;
  // Edges of the slow LCD clock and the active-low resync line
  assign scan.step = pin_s[3] && !st_q.lclk_d;
  assign scan.resync = pin_s[4] && st_q.sync_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr;
  logic is_ldptr;
  logic is_devsel;
  logic is_bank;
  logic is_mode;
  logic [7:0] ptr_sum;
  logic [1:0] phys_row;

  // Commands win over data in the same cycle; the framer never overlaps
  assign wr = data_valid && !cmd_valid;
  // [R21] pointer command
  assign is_ldptr = cmd_valid && !cmd_byte[CMD_LDPTR_BIT];
  // [R22] device-select command
  assign is_devsel = cmd_valid && cmd_byte[7:3] == CMD_DEVSEL_PFX;
  // [R20] bank command
  assign is_bank = cmd_valid && cmd_byte[7:2] == CMD_BANK_PFX;
  assign is_mode = cmd_valid && cmd_byte[7:4] == CMD_MODE_PFX;
  // [R8] store gate
  assign store_match = pin_s[2:0] == st_q.sub;
  assign ptr_sum = {1'b0, st_q.ptr} + lcdw_step(st_q.mode);
  // [R17] output bank swaps in rows 2/3
  assign phys_row = (st_q.bank_out && lcdw_has_banks(st_q.mode)) ?
    (scan.row | BANK_ROW_OFS) : scan.row;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    lcdw_bitmap_t m;
    logic [7:0] col;
    m = '0;
    col = '0;
    st_d = st_q;
    st_d.lclk_d = pin_s[3];
    st_d.sync_d = !pin_s[4];
    if (is_ldptr) begin
      // [R6] pointer load
      st_d.ptr = cmd_byte[6:0];
    end else if (is_devsel) begin
      // [R11] counter load
      st_d.sub = cmd_byte[2:0];
    end else if (is_bank) begin
      // [R19] two independent selectors
      st_d.bank_in = cmd_byte[BANK_IN_BIT];
      st_d.bank_out = cmd_byte[BANK_OUT_BIT];
    end else if (is_mode) begin
      // [R23] mode field
      st_d.mode = lcdw_mode_t'(cmd_byte[1:0]);
    end
    if (wr) begin
      // [R1] [R2] [R3] [R4] [R18] bit placement per mode
      for (int i = 0; i < BYTE_W; i++) begin
        m = lcdw_map_bit(st_q.mode, 3'(i), st_q.bank_in);
        col = {1'b0, st_q.ptr} + {5'h00, m.coff};
        // [R9] [R14] columns past the end are dropped
        if (store_match && col < COL_COUNT) begin
          st_d.ram[col[5:0]][m.row] = data_byte[BYTE_W-1-i];
        end
      end
      // [R5] auto-advance
      if (ptr_sum >= COL_COUNT) begin
        // [R10] [R24] wrap and bump counter together
        st_d.ptr = RST_PTR;
        st_d.sub = st_q.sub + 3'h1;
      end else begin
        st_d.ptr = ptr_sum[6:0];
      end
    end
    if (scan.load) begin
      // [R15] latch the selected row into the display register
      for (int c = 0; c < COLS; c++) begin
        st_d.disp[c] = st_q.ram[c][phys_row];
      end
      st_d.bp = 4'h1 << scan.row;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= CORE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign segment_data = st_q.disp;
  assign segment_out_first = st_q.disp[0];
  assign segment_out_last = st_q.disp[COLS-1];
  assign backplane_out_0 = st_q.bp[0];
  assign backplane_out_1 = st_q.bp[1];
  assign backplane_out_2 = st_q.bp[2];
  assign backplane_out_3 = st_q.bp[3];
  assign row_index = scan.row;
  assign data_ptr = st_q.ptr;
  assign subaddr_cnt = st_q.sub;
  assign drive_mode = st_q.mode;
  assign bank_in_sel = st_q.bank_in;
  assign bank_out_sel = st_q.bank_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ptr_advance_step: // [R5]
    assert property (wr && ptr_sum < COL_COUNT |=>
      st_q.ptr == $past(ptr_sum[6:0]))
    else $error("pointer did not advance by mode step");

  a_ptr_wrap_sub: // [R24]
    assert property (wr && ptr_sum >= COL_COUNT |=>
      st_q.ptr == RST_PTR && st_q.sub == $past(st_q.sub) + 3'h1)
    else $error("overflow did not wrap pointer and bump counter");

  a_ptr_load_cmd: // [R6]
    assert property (is_ldptr |=> st_q.ptr == $past(cmd_byte[6:0]))
    else $error("pointer not loaded from command");

  a_sub_load_cmd: // [R11]
    assert property (is_devsel |=> st_q.sub == $past(cmd_byte[2:0]))
    else $error("counter not loaded from device-select");

  a_discard_on_mismatch: // [R9]
    assert property (wr && !store_match |=> st_q.ram == $past(st_q.ram))
    else $error("RAM changed while subaddress mismatched");

  a_static_row_fill: // [R1]
    assert property (wr && store_match && st_q.mode == MODE_STATIC &&
      !st_q.bank_in && st_q.ptr <= 7'h34 |=>
      st_q.ram[$past(st_q.ptr)][0] == $past(data_byte[7]) &&
      st_q.ram[$past(st_q.ptr) + 7'h7][0] == $past(data_byte[0]))
    else $error("static byte misplaced");

  a_duplex_bank_fill: // [R18]
    assert property (wr && store_match && st_q.mode == MODE_DUPLEX &&
      st_q.bank_in && st_q.ptr <= 7'h38 |=>
      st_q.ram[$past(st_q.ptr)][2] == $past(data_byte[7]) &&
      st_q.ram[$past(st_q.ptr)][3] == $past(data_byte[6]) &&
      st_q.ram[$past(st_q.ptr) + 7'h3][3] == $past(data_byte[0]))
    else $error("two-plane byte not in upper bank");

  a_triple_keep_bit: // [R3]
    assert property (wr && store_match && st_q.mode == MODE_TRIPLE &&
      st_q.ptr <= 7'h39 |=>
      st_q.ram[$past(st_q.ptr) + 7'h2][2] ==
        $past(st_q.ram[st_q.ptr + 7'h2][2]) &&
      st_q.ram[$past(st_q.ptr) + 7'h2][1] == $past(data_byte[0]) &&
      st_q.ram[$past(st_q.ptr)][2] == $past(data_byte[5]))
    else $error("three-plane triple misplaced");

  a_quad_two_cols: // [R4]
    assert property (wr && store_match && st_q.mode == MODE_QUAD &&
      st_q.ptr <= 7'h3A |=>
      st_q.ram[$past(st_q.ptr)][3] == $past(data_byte[4]) &&
      st_q.ram[$past(st_q.ptr) + 7'h1][0] == $past(data_byte[3]))
    else $error("four-plane quadruple misplaced");

  a_bank_sel_split: // [R19]
    assert property (is_bank |=>
      st_q.bank_in == $past(cmd_byte[1]) &&
      st_q.bank_out == $past(cmd_byte[0]))
    else $error("bank selectors not set from command bits");

  a_mode_code_set: // [R23]
    assert property (is_mode |=> st_q.mode == $past(cmd_byte[1:0]))
    else $error("drive mode not taken from command");

  a_out_bank_swap: // [R17]
    assert property (scan.load && st_q.bank_out &&
      st_q.mode == MODE_STATIC |=>
      st_q.disp[5] == $past(st_q.ram[5][2]))
    else $error("output bank did not show row 2");

  a_sub_hold_step: // [R10]
    assert property (wr && ptr_sum < COL_COUNT |=>
      st_q.sub == $past(st_q.sub))
    else $error("counter moved without pointer overflow");

  a_bp_row_phase: // [R15]
    assert property (scan.load |=> st_q.bp == (4'h1 << $past(scan.row)))
    else $error("backplane phase not one-hot of scan row");

  a_disp_row_load: // [R15]
    assert property (scan.load && !st_q.bank_out |=>
      st_q.disp[0] == $past(st_q.ram[0][scan.row]))
    else $error("display register not loaded from scan row");

  a_bank_in_hold: // [R19]
    assert property (!is_bank |=> st_q.bank_in == $past(st_q.bank_in) &&
      st_q.bank_out == $past(st_q.bank_out))
    else $error("bank selector changed without bank command");

  a_static_bank_fill: // [R18]
    assert property (wr && store_match && st_q.mode == MODE_STATIC &&
      st_q.bank_in && st_q.ptr <= 7'h34 |=>
      st_q.ram[$past(st_q.ptr)][2] == $past(data_byte[7]) &&
      st_q.ram[$past(st_q.ptr)][0] == $past(st_q.ram[st_q.ptr][0]))
    else $error("static byte not in upper bank");

  c_ptr_overflow:
    cover property (wr && ptr_sum >= COL_COUNT);

  c_mismatch_discard:
    cover property (wr && !store_match);

  c_bank_display:
    cover property (scan.load && st_q.bank_out &&
      st_q.mode == MODE_DUPLEX);

endmodule : lcdw_top

// File: tb/lcdw_host_model.sv
// Host model issuing command and display bytes to the driver
`timescale 1ns/100ps
module lcdw_host_model (
  // Clock
  input wire logic clk,
  // Byte strobes
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic data_valid,
  output logic [7:0] data_byte
);
  initial begin
    cmd_valid = 1'b0;
    data_valid = 1'b0;
    cmd_byte = 8'h00;
    data_byte = 8'h00;
  end

  // ------
  // Transfers
  // ------
  // Released lines show the inverse so a stale byte never looks valid
  task automatic send(input logic is_cmd, input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= is_cmd;
    data_valid <= ~is_cmd;
    cmd_byte <= is_cmd ? b : cmd_byte;
    data_byte <= is_cmd ? data_byte : b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    data_valid <= 1'b0;
    cmd_byte <= is_cmd ? ~b : cmd_byte;
    data_byte <= is_cmd ? data_byte : ~b;
  endtask : send

  task automatic mode_set(input logic [1:0] m);
    send(1'b1, {4'hC, 1'b1, 1'b0, m});
  endtask : mode_set

  task automatic bank_sel(input logic i, input logic o);
    send(1'b1, {6'h3E, i, o});
  endtask : bank_sel

  task automatic load_ptr(input logic [6:0] p);
    send(1'b1, {1'b0, p});
  endtask : load_ptr

  task automatic select_at(input logic [2:0] a, input logic [6:0] p);
    send(1'b1, {5'h1C, a});
    load_ptr(p);
  endtask : select_at
endmodule : lcdw_host_model

// File: tb/testbench.sv
// Self-checking bench for the display RAM write path
`timescale 1ns/100ps
module testbench import lcdw_pkg::*;;
  logic clk, rst, lcd_clk, lcd_run, sync_pin_n;
  logic [2:0] pins;
  logic cmd_valid, data_valid;
  logic [7:0] cmd_byte, data_byte;
  logic [COLS-1:0] seg;
  logic seg_first, seg_last, bp0, bp1, bp2, bp3;
  logic [1:0] row_idx, mode;
  logic [6:0] ptr;
  logic [2:0] sub;
  logic bin, bout, match;
  int err_count, num_checks, cycles;
  // Expected state
  logic [COLS-1:0] mram [ROWS];
  logic [1:0] m_mode;
  logic m_bin, m_bout;
  logic [6:0] m_ptr;
  logic [2:0] m_sub;

  lcdw_host_model host (.clk, .cmd_valid, .cmd_byte, .data_valid,
    .data_byte);

  lcdw_top dut (.clk, .rst, .cmd_valid, .cmd_byte, .data_valid, .data_byte,
    .hw_subaddr_bit0_pin(pins[0]), .hw_subaddr_bit1_pin(pins[1]),
    .hw_subaddr_bit2_pin(pins[2]), .lcd_clk_pin(lcd_clk), .sync_pin_n,
    .segment_data(seg), .segment_out_first(seg_first),
    .segment_out_last(seg_last), .backplane_out_0(bp0),
    .backplane_out_1(bp1), .backplane_out_2(bp2), .backplane_out_3(bp3),
    .row_index(row_idx), .data_ptr(ptr), .subaddr_cnt(sub),
    .drive_mode(mode), .bank_in_sel(bin), .bank_out_sel(bout),
    .store_match(match));

  // ------
  // Clocks and timeout
  // ------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // LCD clock stands still while a resync is checked
  initial begin
    lcd_clk = 1'b0;
    forever #62.5 lcd_clk = lcd_run & ~lcd_clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ------
  // Helpers
  // ------
  function automatic int width(logic [1:0] m);
    return (m == 2'h1) ? 1 : (m == 2'h2) ? 2 : (m == 2'h3) ? 3 : 4;
  endfunction : width

  task automatic cmp(input string name, input logic [59:0] exp,
                     input logic [59:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Step is ceil(8/width): 8, 4, 3, 2
  task automatic put(input logic [7:0] b);
    int w, c, r, np;
    w = width(m_mode);
    host.send(1'b0, b);
    for (int k = 0; k < 8; k++) begin
      c = m_ptr + k / w;
      r = (m_bin && w <= 2) ? k % w + 2 : k % w;
      if (c < COLS && m_sub == pins) begin
        mram[r][c] = b[7-k];
      end
    end
    np = m_ptr + (8 + w - 1) / w;
    m_ptr = (np >= COLS) ? 7'h00 : 7'(np);
    m_sub = (np >= COLS) ? m_sub + 3'h1 : m_sub;
    settle();
    cmp("data_ptr", 60'(m_ptr), 60'(ptr));
    cmp("subaddr_cnt", 60'(m_sub), 60'(sub));
  endtask : put

  task automatic check_row(input logic [1:0] r);
    logic [1:0] pr;
    pr = (m_bout && width(m_mode) <= 2) ? (r | 2'h2) : r;
    for (int i = 0; i < 30 && row_idx === r; i++) @(negedge clk);
    for (int i = 0; i < 200 && row_idx !== r; i++) @(negedge clk);
    repeat (3) @(posedge clk);
    #1;
    cmp("row_index", 60'(r), 60'(row_idx));
    cmp("backplane", 60'(4'h1 << r), 60'({bp3, bp2, bp1, bp0}));
    cmp("segment_data", mram[pr], seg);
    cmp("segment_ends", 60'({mram[pr][59], mram[pr][0]}),
        60'({seg_last, seg_first}));
  endtask : check_row

  task automatic new_mode(input logic [1:0] m);
    host.mode_set(m);
    m_mode = m;
    settle();
    cmp("drive_mode", 60'(m), 60'(mode));
    lcd_run = 1'b0;
    repeat (10) @(posedge clk);
    sync_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    cmp("resync_row", 60'(width(m) - 1), 60'(row_idx));
    @(posedge clk);
    sync_pin_n <= 1'b1;
    lcd_run = 1'b1;
  endtask : new_mode

  // ------
  // Main sequence
  // ------
  initial begin
    rst = 1'b1;
    sync_pin_n = 1'b1;
    lcd_run = 1'b0;
    pins = 3'h0;
    {m_mode, m_bin, m_bout, m_ptr, m_sub} = '0;
    for (int r = 0; r < ROWS; r++) mram[r] = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("reset_ptr", 60'h0, 60'(ptr));
    cmp("reset_sub", 60'h0, 60'(sub));
    cmp("reset_mode", 60'h0, 60'(mode));
    cmp("reset_banks", 60'h0, 60'({bin, bout}));
    cmp("reset_row", 60'h0, 60'(row_idx));
    for (int i = 0; i < 4; i++) begin
      new_mode(2'(i + 1));
      host.select_at(3'h0, 7'h0A);
      m_ptr = 7'h0A;
      settle();
      cmp("loaded_ptr", 60'h0A, 60'(ptr));
      put(8'hA5);
      host.load_ptr(7'h0C);
      m_ptr = 7'h0C;
      put(8'h3C);
      for (int r = 0; r < width(m_mode); r++) check_row(2'(r));
    end
    new_mode(2'h1);
    host.bank_sel(1'b1, 1'b0);
    {m_bin, m_bout} = 2'b10;
    host.load_ptr(7'h14);
    m_ptr = 7'h14;
    put(8'h81);
    cmp("bank_sel", 60'h2, 60'({bin, bout}));
    check_row(2'h0);
    host.bank_sel(1'b0, 1'b1);
    {m_bin, m_bout} = 2'b01;
    settle();
    cmp("bank_sel", 60'h1, 60'({bin, bout}));
    check_row(2'h0);
    // Two-plane banks: write rows 2 and 3, show row 3
    new_mode(2'h2);
    host.bank_sel(1'b1, 1'b1);
    {m_bin, m_bout} = 2'b11;
    host.load_ptr(7'h20);
    m_ptr = 7'h20;
    put(8'h96);
    check_row(2'h1);
    host.bank_sel(1'b0, 1'b0);
    {m_bin, m_bout} = 2'b00;
    new_mode(2'h0);
    host.select_at(3'h1, 7'h3A);
    m_sub = 3'h1;
    m_ptr = 7'h3A;
    settle();
    cmp("store_match", 60'h0, 60'(match));
    put(8'hFF);
    @(posedge clk);
    pins <= 3'h2;
    repeat (4) @(posedge clk);
    #1;
    cmp("store_match", 60'h1, 60'(match));
    put(8'hF0);
    check_row(2'h0);
    check_row(2'h1);
    summarize();
  end
endmodule : testbench
